/* ccde_pkg.sv */
package ccde_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int LIT_W = 11;
  localparam int PC_W = 13;
  localparam int JHL_W = 5;

  // ------------------------------------------------------------
  // instruction encodings (mask, match)
  // ------------------------------------------------------------
  localparam logic [13:0] CALL_MASK = 14'h3800;
  localparam logic [13:0] CALL_CODE = 14'h2000;
  localparam logic [13:0] FOP_MASK = 14'h3f00;
  localparam logic [13:0] INVERT_CODE = 14'h0900;
  localparam logic [13:0] MINUS_CODE = 14'h0300;
  localparam logic [13:0] SKIP_CODE = 14'h0b00;
  localparam logic [13:0] FZERO_MASK = 14'h3f80;
  localparam logic [13:0] FZERO_CODE = 14'h0180;
  localparam logic [13:0] WZERO_CODE = 14'h0100;
  localparam logic [13:0] NOP_CODE = 14'h0000;
  localparam int DEST_BIT = 7;
  localparam int JHL_LO = 3;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] JHL_OFF = 8'h04;
  localparam logic [7:0] WREG_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0c;
  localparam logic [7:0] PC_OFF = 8'h10;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_FLUSH_BIT = 1;
  localparam int STAT_UNSUP_BIT = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic [4:0] JHL_RST = 5'h00;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [12:0] PC_RST = 13'h0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_CALL = 3'b001,
    OP_INVERT = 3'b010,
    OP_FZERO = 3'b011,
    OP_MINUS = 3'b100,
    OP_WZERO = 3'b101,
    OP_SKIP = 3'b110,
    OP_UNSUP = 3'b111
  } ccde_op_e;

  typedef enum logic [1:0] {
    ALU_INV = 2'b00,
    ALU_DEC = 2'b01,
    ALU_CLR = 2'b10
  } ccde_alu_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_CALL_FLUSH = 2'b01,
    ST_SKIP_FLUSH = 2'b10
  } ccde_state_e;

endpackage : ccde_pkg

/* ccde_alu.sv */
`timescale 1ns/1ps
module ccde_alu (
  input wire ccde_pkg::ccde_alu_e op,
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic zero
);

  always_comb begin
    case (op)
      ccde_pkg::ALU_INV: result = ~operand;
      ccde_pkg::ALU_DEC: result = operand - 8'h01;
      ccde_pkg::ALU_CLR: result = 8'h00;
      default: result = 8'h00;
    endcase
    zero = (result == 8'h00);
  end

endmodule : ccde_alu

/* ccde_exec.sv */
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ccde_exec #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  output logic [12:0] program_counter,
  output logic [6:0] file_rd_addr,
  input wire logic [7:0] file_rd_data,
  output logic file_wr_en,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic stack_push,
  output logic [12:0] stack_top,
  output logic [7:0] working_reg,
  output logic zero_flag
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
    $error("ccde_exec: ADDR_W must lie between 5 and 32");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic ccde_pkg::ccde_op_e decode_op(input logic [13:0] w);
    if ((w & ccde_pkg::CALL_MASK) == ccde_pkg::CALL_CODE) return ccde_pkg::OP_CALL;
    if ((w & ccde_pkg::FOP_MASK) == ccde_pkg::INVERT_CODE) return ccde_pkg::OP_INVERT;
    if ((w & ccde_pkg::FOP_MASK) == ccde_pkg::MINUS_CODE) return ccde_pkg::OP_MINUS;
    if ((w & ccde_pkg::FOP_MASK) == ccde_pkg::SKIP_CODE) return ccde_pkg::OP_SKIP;
    if ((w & ccde_pkg::FZERO_MASK) == ccde_pkg::FZERO_CODE) return ccde_pkg::OP_FZERO;
    if ((w & ccde_pkg::FZERO_MASK) == ccde_pkg::WZERO_CODE) return ccde_pkg::OP_WZERO;
    if (w == ccde_pkg::NOP_CODE) return ccde_pkg::OP_NOP;
    return ccde_pkg::OP_UNSUP;
  endfunction : decode_op

  function automatic logic reg_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return (a[ADDR_W-1:2] == (ADDR_W-2)'(off >> 2));
  endfunction : reg_is

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic run_r, run_nxt;
  logic [4:0] jhl_r, jhl_nxt;
  logic [7:0] w_r, w_nxt;
  logic z_r, z_nxt;
  logic unsup_r, unsup_nxt;
  logic [12:0] pc_r, pc_nxt;
  ccde_pkg::ccde_state_e st_r, st_nxt;
  logic fwe_r, fwe_nxt;
  logic [6:0] fwa_r, fwa_nxt;
  logic [7:0] fwd_r, fwd_nxt;
  logic push_r, push_nxt;
  logic [12:0] tos_r, tos_nxt;

  logic aw_held_r, aw_held_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [7:0] w_data_r, w_data_nxt;
  logic w_lane0_r, w_lane0_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  logic take;
  ccde_pkg::ccde_op_e op;
  ccde_pkg::ccde_alu_e alu_op;
  logic [7:0] operand;
  logic [7:0] alu_res;
  logic alu_zero;
  logic dest_file;
  logic do_wr;
  logic sw_wr_ctrl, sw_wr_jhl, sw_wr_wreg, sw_wr_stat;

  assign take = instr_valid && instr_ready;
  assign op = decode_op(instr_word);
  assign dest_file = instr_word[ccde_pkg::DEST_BIT];
  assign file_rd_addr = instr_word[6:0];
  // a write still leaving on the port is not yet in the file; forward it
  assign operand = (fwe_r && fwa_r == instr_word[6:0]) ? fwd_r : file_rd_data;

  always_comb begin
    case (op)
      ccde_pkg::OP_INVERT: alu_op = ccde_pkg::ALU_INV;
      ccde_pkg::OP_FZERO: alu_op = ccde_pkg::ALU_CLR;
      default: alu_op = ccde_pkg::ALU_DEC;
    endcase
  end

  ccde_alu u_alu (
    .op(alu_op),
    .operand(operand),
    .result(alu_res),
    .zero(alu_zero)
  );

  // ------------------------------------------------------------
  // execution
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    w_nxt = w_r;
    z_nxt = z_r;
    fwe_nxt = 1'b0;
    fwa_nxt = fwa_r;
    fwd_nxt = fwd_r;
    push_nxt = 1'b0;
    tos_nxt = tos_r;
    unsup_nxt = unsup_r;
    if (sw_wr_stat && w_data_r[ccde_pkg::STAT_UNSUP_BIT]) begin
      unsup_nxt = 1'b0;
    end
    if (sw_wr_wreg) begin
      w_nxt = w_data_r;
    end
    if (take) begin
      case (st_r)
        ccde_pkg::ST_RUN: begin
          pc_nxt = pc_r + 13'h0001;
          case (op)
            ccde_pkg::OP_CALL: begin
              push_nxt = 1'b1;
              tos_nxt = pc_r + 13'h0001;
              // upper bits from the latch, lower from the literal, flags untouched
              pc_nxt = {jhl_r[ccde_pkg::JHL_LO+1:ccde_pkg::JHL_LO], instr_word[10:0]};
              st_nxt = ccde_pkg::ST_CALL_FLUSH;
            end
            ccde_pkg::OP_FZERO: begin
              fwe_nxt = 1'b1;
              fwa_nxt = instr_word[6:0];
              fwd_nxt = alu_res;
              z_nxt = 1'b1;
            end
            ccde_pkg::OP_WZERO: begin
              w_nxt = 8'h00;
              z_nxt = 1'b1;
            end
            ccde_pkg::OP_INVERT, ccde_pkg::OP_MINUS, ccde_pkg::OP_SKIP: begin
              if (dest_file) begin
                fwe_nxt = 1'b1;
                fwa_nxt = instr_word[6:0];
                fwd_nxt = alu_res;
              end else begin
                w_nxt = alu_res;
              end
              if (op != ccde_pkg::OP_SKIP) begin
                z_nxt = alu_zero;
              end
              if (op == ccde_pkg::OP_SKIP && alu_zero) begin
                st_nxt = ccde_pkg::ST_SKIP_FLUSH;
              end
            end
            ccde_pkg::OP_UNSUP: begin
              unsup_nxt = 1'b1;
            end
            default: begin
            end
          endcase
        end
        ccde_pkg::ST_CALL_FLUSH: begin
          // word prefetched behind the call is dropped; counter already at target
          st_nxt = ccde_pkg::ST_RUN;
        end
        ccde_pkg::ST_SKIP_FLUSH: begin
          pc_nxt = pc_r + 13'h0001;
          st_nxt = ccde_pkg::ST_RUN;
        end
        default: begin
          st_nxt = ccde_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ccde_pkg::ST_RUN;
      pc_r <= ccde_pkg::PC_RST;
      w_r <= ccde_pkg::WREG_RST;
      z_r <= ccde_pkg::ZERO_RST;
      fwe_r <= 1'b0;
      fwa_r <= 7'h00;
      fwd_r <= 8'h00;
      push_r <= 1'b0;
      tos_r <= 13'h0000;
      unsup_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      w_r <= w_nxt;
      z_r <= z_nxt;
      fwe_r <= fwe_nxt;
      fwa_r <= fwa_nxt;
      fwd_r <= fwd_nxt;
      push_r <= push_nxt;
      tos_r <= tos_nxt;
      unsup_r <= unsup_nxt;
    end
  end

  assign instr_ready = run_r;
  assign program_counter = pc_r;
  assign file_wr_en = fwe_r;
  assign file_wr_addr = fwa_r;
  assign file_wr_data = fwd_r;
  assign stack_push = push_r;
  assign stack_top = tos_r;
  assign working_reg = w_r;
  assign zero_flag = z_r;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  // only byte lane 0 carries writable register bits; other lanes are ignored
  assign do_wr = aw_held_r && w_held_r && !bvalid_r;
  assign sw_wr_ctrl = do_wr && w_lane0_r && reg_is(aw_addr_r, ccde_pkg::CTRL_OFF);
  assign sw_wr_jhl = do_wr && w_lane0_r && reg_is(aw_addr_r, ccde_pkg::JHL_OFF);
  assign sw_wr_wreg = do_wr && w_lane0_r && reg_is(aw_addr_r, ccde_pkg::WREG_OFF);
  assign sw_wr_stat = do_wr && w_lane0_r && reg_is(aw_addr_r, ccde_pkg::STAT_OFF);
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    run_nxt = run_r;
    jhl_nxt = jhl_r;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[7:0];
      w_lane0_nxt = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      if (reg_is(aw_addr_r, ccde_pkg::CTRL_OFF) || reg_is(aw_addr_r, ccde_pkg::JHL_OFF) ||
          reg_is(aw_addr_r, ccde_pkg::WREG_OFF) || reg_is(aw_addr_r, ccde_pkg::STAT_OFF) ||
          reg_is(aw_addr_r, ccde_pkg::PC_OFF)) begin
        bresp_nxt = ccde_pkg::RESP_OKAY;
      end else begin
        bresp_nxt = ccde_pkg::RESP_SLVERR;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (sw_wr_ctrl) begin
      run_nxt = w_data_r[ccde_pkg::CTRL_RUN_BIT];
    end
    if (sw_wr_jhl) begin
      jhl_nxt = w_data_r[4:0];
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = ccde_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (reg_is(s_axi_araddr, ccde_pkg::CTRL_OFF)) begin
        rdata_nxt[ccde_pkg::CTRL_RUN_BIT] = run_r;
      end else if (reg_is(s_axi_araddr, ccde_pkg::JHL_OFF)) begin
        rdata_nxt[4:0] = jhl_r;
      end else if (reg_is(s_axi_araddr, ccde_pkg::WREG_OFF)) begin
        rdata_nxt[7:0] = w_r;
      end else if (reg_is(s_axi_araddr, ccde_pkg::STAT_OFF)) begin
        rdata_nxt[ccde_pkg::STAT_ZERO_BIT] = z_r;
        rdata_nxt[ccde_pkg::STAT_FLUSH_BIT] = (st_r != ccde_pkg::ST_RUN);
        rdata_nxt[ccde_pkg::STAT_UNSUP_BIT] = unsup_r;
      end else if (reg_is(s_axi_araddr, ccde_pkg::PC_OFF)) begin
        rdata_nxt[12:0] = pc_r;
      end else begin
        rresp_nxt = ccde_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= ccde_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ccde_pkg::RESP_OKAY;
      run_r <= ccde_pkg::CTRL_RUN_RST;
      jhl_r <= ccde_pkg::JHL_RST;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_lane0_r <= w_lane0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      run_r <= run_nxt;
      jhl_r <= jhl_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : ccde_exec

/* ccde_file_model.sv */
`timescale 1ns/1ps
module ccde_file_model (
  input wire logic aclk,
  input wire logic [6:0] file_rd_addr,
  output logic [7:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [6:0] file_wr_addr,
  input wire logic [7:0] file_wr_data
);
  // --------------------
  // data file
  // --------------------
  logic [7:0] mem [128];
  // read is combinational: the unit takes its operand in the same cycle
  assign file_rd_data = mem[file_rd_addr];
  always @(posedge aclk) begin
    if (file_wr_en) mem[file_wr_addr] <= file_wr_data;
  end
endmodule : ccde_file_model

/* ccde_exec_checker.sv */
`timescale 1ns/1ps
module ccde_exec_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic instr_ready,
  input wire logic [12:0] program_counter,
  input wire logic [7:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [6:0] file_wr_addr,
  input wire logic [7:0] file_wr_data,
  input wire logic stack_push,
  input wire logic [12:0] stack_top,
  input wire logic [7:0] working_reg,
  input wire logic zero_flag
);
  // --------------------
  // slot tracking
  // --------------------
  logic fl_r;
  logic fl_nxt;
  logic go;
  logic tk;
  logic [13:0] op;
  logic [7:0] opnd;
  assign go = instr_valid && instr_ready;
  assign tk = go && !fl_r;
  assign op = instr_word & ccde_pkg::FOP_MASK;
  // last write forwarded, as the unit does
  assign opnd = (file_wr_en && file_wr_addr == instr_word[6:0]) ? file_wr_data : file_rd_data;
  always_comb begin
    fl_nxt = fl_r;
    if (go) fl_nxt = tk && ((instr_word & ccde_pkg::CALL_MASK) == ccde_pkg::CALL_CODE
      || op == ccde_pkg::SKIP_CODE && opnd == 8'h01);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) fl_r <= 1'b0;
    else fl_r <= fl_nxt;
  end
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_call;
    tk && (instr_word & ccde_pkg::CALL_MASK) == ccde_pkg::CALL_CODE;
  endsequence
  sequence s_skip0;
    tk && op == ccde_pkg::SKIP_CODE && opnd == 8'h01;
  endsequence
  chk_call_push:
    assert property (s_call |=> stack_push && stack_top == $past(program_counter) + 13'h0001)
    else $error("call return address wrong");
  chk_call_low:
    assert property (s_call |=> program_counter[10:0] == $past(instr_word[10:0]))
    else $error("call target low bits wrong");
  chk_call_slot:
    assert property (s_call ##1 go |=> $stable(program_counter) && !file_wr_en && !stack_push)
    else $error("word after call not dropped");
  chk_call_flags:
    assert property (s_call |=> $stable(zero_flag)) else $error("call changed zero");
  chk_acc_zero:
    assert property (tk && (instr_word & ccde_pkg::FZERO_MASK) == ccde_pkg::WZERO_CODE
      |=> working_reg == 8'h00 && zero_flag && !file_wr_en) else $error("accumulator clear");
  chk_file_zero:
    assert property (tk && (instr_word & ccde_pkg::FZERO_MASK) == ccde_pkg::FZERO_CODE
      |=> file_wr_en && file_wr_data == 8'h00 && file_wr_addr == $past(instr_word[6:0])
      && zero_flag) else $error("file clear wrong");
  chk_invert_file:
    assert property (tk && op == ccde_pkg::INVERT_CODE && instr_word[7] |=> file_wr_en
      && file_wr_data == ~$past(opnd) && zero_flag == ($past(opnd) == 8'hff))
    else $error("invert to file wrong");
  chk_minus_acc:
    assert property (tk && op == ccde_pkg::MINUS_CODE && !instr_word[7] |=> !file_wr_en
      && working_reg == $past(opnd) - 8'h01 && zero_flag == ($past(opnd) == 8'h01))
    else $error("decrement to accumulator wrong");
  chk_skip_flag:
    assert property (tk && op == ccde_pkg::SKIP_CODE |=> $stable(zero_flag))
    else $error("skip changed zero");
  chk_skip_drop:
    assert property (s_skip0 ##1 go |=> !file_wr_en
      && program_counter == $past(program_counter) + 13'h0001) else $error("skip slot wrong");
  chk_single_cycle:
    assert property (tk && (op == ccde_pkg::INVERT_CODE || op == ccde_pkg::MINUS_CODE)
      |=> !stack_push && program_counter == $past(program_counter) + 13'h0001)
    else $error("single cycle op wrong");
endmodule : ccde_exec_checker

bind ccde_exec ccde_exec_checker u_chk (.aclk, .aresetn, .instr_valid, .instr_word,
  .instr_ready, .program_counter, .file_rd_data, .file_wr_en, .file_wr_addr, .file_wr_data,
  .stack_push, .stack_top, .working_reg, .zero_flag);

/* ccde_exec_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module ccde_exec_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, instr_valid = 0;
  logic [13:0] instr_word = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [12:0] program_counter, stack_top;
  logic [6:0] file_rd_addr, file_wr_addr;
  logic [7:0] file_rd_data, file_wr_data, working_reg;
  logic file_wr_en, stack_push, zero_flag;
  int comparisons = 0, miscompares = 0;
  logic [39:0] exp_q [$];
  logic [31:0] rnd = 32'hcf1c_5ec8;
  logic [7:0] w_m = '0;
  logic [12:0] pc_m = '0;
  logic [4:0] jhl_m = '0;
  logic z_m = 0, u_m = 0;
  logic [13:0] codes [5] = '{ccde_pkg::INVERT_CODE, ccde_pkg::FZERO_CODE,
    ccde_pkg::MINUS_CODE, ccde_pkg::WZERO_CODE, ccde_pkg::SKIP_CODE};

  ccde_exec #(.ADDR_W(8)) u_ccde_exec (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_valid, .instr_word, .instr_ready,
    .program_counter, .file_rd_addr, .file_rd_data, .file_wr_en, .file_wr_addr,
    .file_wr_data, .stack_push, .stack_top, .working_reg, .zero_flag);
  ccde_file_model m_file (.aclk, .file_rd_addr, .file_rd_data, .file_wr_en, .file_wr_addr,
    .file_wr_data);

  initial forever #25 aclk = ~aclk;

  // --------------------
  // tasks
  // --------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({4'h4, 34'h0, r});
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no local limit: only the watchdog may end a wait
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // one idle edge so a following call never re-drives bready in this step
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back({4'h3, 2'h0, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axr
  task automatic ex(input logic [13:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge aclk);
  endtask : ex
  task automatic check_state(input string n);
    instr_valid <= 1'b0;
    @(posedge aclk);
    axr(ccde_pkg::WREG_OFF, {26'h0, w_m});
    axr(ccde_pkg::STAT_OFF, {31'h0, u_m, 1'b0, z_m});
    axr(ccde_pkg::PC_OFF, {21'h0, pc_m});
    $display("test %s done", n);
  endtask : check_state
  task automatic fop(input logic [13:0] c, input logic [6:0] a, input logic [7:0] v,
    input logic d);
    logic [7:0] r;
    m_file.mem[a] = v;
    r = (c == ccde_pkg::INVERT_CODE) ? ~v : v - 8'h01;
    if (c == ccde_pkg::FZERO_CODE || c == ccde_pkg::WZERO_CODE) r = 8'h00;
    if (c != ccde_pkg::SKIP_CODE) z_m = (r == 8'h00);
    if (c == ccde_pkg::FZERO_CODE) d = 1'b1;
    if (c == ccde_pkg::WZERO_CODE) d = 1'b0;
    if (d) exp_q.push_back({4'h1, 21'h0, a, r});
    else w_m = r;
    ex(c | {6'h0, d, a});
    pc_m = pc_m + 13'h0001;
    // an invert-to-file that is not dropped would show up as an unexpected write
    if (c == ccde_pkg::SKIP_CODE && r == 8'h00) begin
      ex(ccde_pkg::INVERT_CODE | 14'h00ff);
      pc_m = pc_m + 13'h0001;
    end
  endtask : fop
  task automatic take(input string n, input logic [39:0] g);
    logic [39:0] e;
    e = '1;
    if (exp_q.size() != 0) e = exp_q.pop_front();
    `CHK(n, e, g)
  endtask : take

  // --------------------
  // result monitor
  // --------------------
  always @(posedge aclk) begin
    if (aresetn && file_wr_en) take("file write", {4'h1, 21'h0, file_wr_addr, file_wr_data});
    if (aresetn && stack_push) take("stack push", {4'h2, 23'h0, stack_top});
    if (s_axi_bvalid && s_axi_bready) take("write resp", {4'h4, 34'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) take("read", {4'h3, 2'h0, s_axi_rresp, s_axi_rdata});
  end

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    close_out;
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) axr(8'(4 * i), 34'h0);
    axr(8'h14, {ccde_pkg::RESP_SLVERR, 32'h0000_0000});
    axw(8'h14, 32'h0000_0001, ccde_pkg::RESP_SLVERR);
    $display("test reset done");
    axw(ccde_pkg::CTRL_OFF, 32'h0000_0001, ccde_pkg::RESP_OKAY);
    for (int i = 0; i < 20; i++) begin
      rnd = lfsr(rnd);
      fop(codes[i % 5], 7'(i) + 7'h10, (i < 5) ? 8'h01 : (i < 10) ? 8'h00 : (i < 15) ? 8'hff
        : rnd[7:0], (i < 10) ? i[0] : rnd[15]);
      if (i % 2 == 1) check_state("file ops");
    end
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      jhl_m = rnd[24:20];
      axw(ccde_pkg::JHL_OFF, {27'h0, jhl_m}, ccde_pkg::RESP_OKAY);
      exp_q.push_back({4'h2, 23'h0, pc_m + 13'h0001});
      ex(ccde_pkg::CALL_CODE | {3'h0, (i == 0) ? 11'h7ff : rnd[10:0]});
      pc_m = {jhl_m[4:3], (i == 0) ? 11'h7ff : rnd[10:0]};
      ex(ccde_pkg::INVERT_CODE | 14'h00ff);
      fop(ccde_pkg::SKIP_CODE, 7'h30, 8'h01, rnd[16]);
      check_state("call");
    end
    ex(14'h3fff);
    pc_m = pc_m + 13'h0001;
    u_m = 1'b1;
    check_state("unsupported");
    axw(ccde_pkg::STAT_OFF, 32'h0000_0004, ccde_pkg::RESP_OKAY);
    u_m = 1'b0;
    check_state("sticky clear");
    `CHK("leftover", 32'h0000_0000, 32'(exp_q.size()))
    close_out;
  end
endmodule : ccde_exec_test
